// [rtl/gpmc_ctrl.sv]
/*
  Gauge power and measurement controller: power states, conversion schedule,
  current offset, gain and tempco correction, charge accumulation.
  Assumes converter front ends and the single-wire protocol engine share sys_clk;
  only the data line pin is asynchronous.
*/
`timescale 1ns/10ps
module gpmc_ctrl import gpmc_pkg::*; #(
  parameter int SLEEP_CYCLES = SLEEP_CYC,
  parameter int VOLT_CYCLES = VOLT_CYC,
  parameter int CUR_CYCLES = CUR_CYC,
  parameter logic [15:0] FACTORY_GAIN = FACTORY_GAIN_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dq_in,
  input wire gpmc_sleep_cfg_t sleep_cfg,
  input wire logic signed [RAW_W-1:0] pack_voltage_input,
  input wire logic signed [TEMP_W-1:0] temp_raw,
  input wire logic signed [RAW_W-1:0] sense_input,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic adc_sample,
  output logic adc_offset_mode,
  output logic meas_strobe,
  output logic cur_strobe,
  output gpmc_results_t results,
  output logic signed [ACC_W-1:0] charge_accumulator,
  output logic sleep_mode,
  output logic presence_suppress
);

  localparam int VCNT_W = $clog2(VOLT_CYCLES + 1);
  localparam int CCNT_W = $clog2(CUR_CYCLES + 1);
  localparam int SCNT_W = $clog2(SAMPLE_CYC + 1);
  localparam logic [VCNT_W-1:0] VCNT_LAST = VCNT_W'(VOLT_CYCLES - 1);
  localparam logic [CCNT_W-1:0] CCNT_LAST = CCNT_W'(CUR_CYCLES - 1);
  localparam logic [SCNT_W-1:0] SCNT_LAST = SCNT_W'(SAMPLE_CYC - 1);
  localparam logic [CONV_CNT_W-1:0] OFFSET_SLOT = '1;

  // ****************************************
  // data line watch
  // ****************************************
  logic line_lvl;
  logic line_rise;
  logic line_edge;
  logic line_static;

  gpmc_line_watch #(.STATIC_CYC(SLEEP_CYCLES)) u_line (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .line_pin(dq_in),
    .line_lvl(line_lvl),
    .line_rise(line_rise),
    .line_edge(line_edge),
    .line_static(line_static)
  );

  // ****************************************
  // power state
  // ****************************************
  gpmc_pwr_t state;
  gpmc_pwr_t next_state;
  logic active;
  logic uv_low;
  logic bus_sleep_req;
  logic uv_sleep_req;
  logic next_suppress;

  // undervoltage compares the last stored voltage, so it reacts once per 440ms
  assign uv_low = $signed(results.volt) <
                  $signed(sleep_cfg.vsel_high ? SLEEP_VOLTAGE_THRESHOLD_HI : SLEEP_VOLTAGE_THRESHOLD_LO);
  assign bus_sleep_req = sleep_cfg.bus_low_en & line_static & ~line_lvl;
  assign uv_sleep_req = sleep_cfg.uv_en & uv_low & line_static;
  assign active = (state == GPMC_ACTIVE);
  assign sleep_mode = ~active;

  // bus-low entry is checked first; it also covers a low static line
  always_comb begin
    next_state = state;
    unique case (state)
      GPMC_ACTIVE: begin
        if (bus_sleep_req) begin
          next_state = GPMC_SLEEP_BUS;
        end else if (uv_sleep_req) begin
          next_state = GPMC_SLEEP_UV;
        end
      end
      GPMC_SLEEP_BUS: begin
        if (line_lvl) begin
          next_state = GPMC_ACTIVE;
        end
      end
      GPMC_SLEEP_UV: begin
        if (line_edge) begin
          next_state = GPMC_ACTIVE;
        end
      end
    endcase
  end

  // armed when sleeping with the line low; the first rise is not answered
  assign next_suppress = ((next_state != GPMC_ACTIVE) & ~line_lvl) |
                         (presence_suppress & ~line_rise);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= GPMC_ACTIVE;
      presence_suppress <= 1'b0;
    end else begin
      state <= next_state;
      presence_suppress <= next_suppress;
    end
  end

  // ****************************************
  // conversion schedule
  // ****************************************
  logic [VCNT_W-1:0] volt_cnt;
  logic [CCNT_W-1:0] cur_cnt;
  logic [SCNT_W-1:0] samp_cnt;
  logic [CONV_CNT_W-1:0] conv_cnt;
  logic volt_end;
  logic cur_end;
  logic offset_conv;

  assign volt_end = active & (volt_cnt == VCNT_LAST);
  assign cur_end = active & (cur_cnt == CCNT_LAST);
  assign adc_sample = active & (samp_cnt == SCNT_LAST);
  assign offset_conv = (conv_cnt == OFFSET_SLOT);
  assign adc_offset_mode = active & offset_conv;
  assign meas_strobe = volt_end;
  assign cur_strobe = cur_end;

  // counters freeze in sleep so a wake resumes the same conversion phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_cnt <= '0;
      cur_cnt <= '0;
      samp_cnt <= '0;
      conv_cnt <= '0;
    end else if (active) begin
      volt_cnt <= volt_end ? '0 : volt_cnt + VCNT_W'(1);
      cur_cnt <= cur_end ? '0 : cur_cnt + CCNT_W'(1);
      samp_cnt <= adc_sample ? '0 : samp_cnt + SCNT_W'(1);
      conv_cnt <= cur_end ? conv_cnt + CONV_CNT_W'(1) : conv_cnt;
    end
  end

  // ****************************************
  // trim registers
  // ****************************************
  logic signed [7:0] offset_trim;
  logic [15:0] gain_trim;
  logic [TC_W-1:0] tempco_trim;

  // offset trim is volatile and starts at zero after every power-up
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_trim <= '0;
      gain_trim <= FACTORY_GAIN;
      tempco_trim <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_COB) offset_trim <= reg_wdata;
      if (reg_addr == ADDR_GAIN_MSB) gain_trim[15:8] <= reg_wdata;
      if (reg_addr == ADDR_GAIN_LSB) gain_trim[7:0] <= reg_wdata;
      if (reg_addr == ADDR_TC) tempco_trim <= reg_wdata;
    end
  end

  // ****************************************
  // current datapath
  // ****************************************
  logic signed [RAW_W-1:0] offset_corr;
  logic signed [17:0] cur_biased;
  logic signed [29:0] cur_gain_full;
  logic signed [19:0] cur_gained;
  logic signed [18:0] comp_term;
  logic signed [38:0] comp_full;
  logic signed [20:0] cur_comp;
  logic signed [CUR_W-1:0] cur_next;
  logic signed [CUR_W-1:0] cur_acc_in;
  logic signed [9:0] temp_dev;
  logic signed [18:0] comp_calc;

  function automatic logic signed [CUR_W-1:0] sat_cur(input logic signed [20:0] v);
    if (v > 21'(CUR_MAX)) begin
      sat_cur = CUR_MAX;
    end else if (v < 21'(CUR_MIN)) begin
      sat_cur = CUR_MIN;
    end else begin
      sat_cur = v[CUR_W-1:0];
    end
  endfunction

  function automatic logic signed [VOLT_W-1:0] sat_volt(input logic signed [RAW_W-1:0] v);
    logic signed [RAW_W-1:0] lim_hi;
    logic signed [RAW_W-1:0] lim_lo;
    lim_hi = RAW_W'({1'b0, {(VOLT_W-1){1'b1}}});
    lim_lo = -lim_hi - RAW_W'(1);
    if (v > lim_hi) begin
      sat_volt = {1'b0, {(VOLT_W-1){1'b1}}};
    end else if (v < lim_lo) begin
      sat_volt = {1'b1, {(VOLT_W-1){1'b0}}};
    end else begin
      sat_volt = v[VOLT_W-1:0];
    end
  endfunction

  // offset removed and trim added before gain; the trim is the user's skew
  assign cur_biased = 18'(sense_input) - 18'(offset_corr) + 18'(offset_trim);
  assign cur_gain_full = cur_biased * $signed({1'b0, gain_trim[GAIN_W-1:0]});
  assign cur_gained = cur_gain_full[29:GAIN_FRAC];
  // resistance grows with heat, so the reading is pulled down by the term
  assign comp_full = cur_gained * comp_term;
  assign cur_comp = 21'(cur_gained) - 21'($signed(comp_full[38:TC_SHIFT]));
  assign cur_next = sat_cur(cur_comp);
  // the offset slot has no sample; the previous result stands in for it
  assign cur_acc_in = offset_conv ? results.current : cur_next;

  // deviation in half degrees; a zero coefficient gives a zero term
  assign temp_dev = 10'($signed(results.temp[TEMP_W-1:2])) - TC_REF_HALF;
  // both factors widened first so the product cannot wrap at ten bits
  assign comp_calc = 19'($signed({1'b0, tempco_trim})) * 19'(temp_dev);

  // term follows temperature only on half-degree crossings or a new coefficient
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_term <= '0;
    end else begin
      comp_term <= comp_calc;
    end
  end

  // ****************************************
  // result and accumulator registers
  // ****************************************
  logic signed [ACC_W:0] acc_sum;
  logic signed [ACC_W-1:0] acc_next;

  assign acc_sum = (ACC_W+1)'(charge_accumulator) + (ACC_W+1)'(cur_acc_in);
  assign acc_next = (acc_sum[ACC_W] != acc_sum[ACC_W-1]) ?
                    {acc_sum[ACC_W], {(ACC_W-1){~acc_sum[ACC_W]}}} :
                    acc_sum[ACC_W-1:0];

  // nothing here moves while asleep, because the strobes need active
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      results <= '0;
      offset_corr <= '0;
      charge_accumulator <= '0;
    end else begin
      if (volt_end) begin
        results.volt <= sat_volt(pack_voltage_input);
        results.temp <= temp_raw;
      end
      if (cur_end) begin
        if (offset_conv) begin
          offset_corr <= sense_input;
        end else begin
          results.current <= cur_next;
        end
        charge_accumulator <= acc_next;
      end
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  logic [15:0] volt_word;
  logic [15:0] temp_word;
  logic [7:0] next_rdata;

  assign volt_word = 16'(results.volt);
  assign temp_word = 16'(results.temp);
  // unmapped addresses read zero; the factory copy has no write path
  assign next_rdata =
    (reg_addr == ADDR_TEMP_MSB) ? temp_word[15:8] :
    (reg_addr == ADDR_TEMP_LSB) ? temp_word[7:0] :
    (reg_addr == ADDR_VOLT_MSB) ? volt_word[15:8] :
    (reg_addr == ADDR_VOLT_LSB) ? volt_word[7:0] :
    (reg_addr == ADDR_CUR_MSB) ? results.current[15:8] :
    (reg_addr == ADDR_CUR_LSB) ? results.current[7:0] :
    (reg_addr == ADDR_COB) ? offset_trim :
    (reg_addr == ADDR_GAIN_MSB) ? gain_trim[15:8] :
    (reg_addr == ADDR_GAIN_LSB) ? gain_trim[7:0] :
    (reg_addr == ADDR_TC) ? tempco_trim :
    (reg_addr == ADDR_FGAIN_MSB) ? FACTORY_GAIN[15:8] :
    (reg_addr == ADDR_FGAIN_LSB) ? FACTORY_GAIN[7:0] : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sleep_holds_a: assert property (sleep_mode && $past(sleep_mode) |->
      $stable(results) && $stable(charge_accumulator))
    else $error("results changed while asleep");

  bus_sleep_a: assert property (active && bus_sleep_req |=> state == GPMC_SLEEP_BUS)
    else $error("bus-low sleep not entered");

  bus_wake_a: assert property (state == GPMC_SLEEP_BUS && line_lvl |=> active)
    else $error("bus-low sleep did not wake on high line");

  uv_sleep_a: assert property (active && !bus_sleep_req && sleep_cfg.uv_en && uv_low
      && line_static |=> state == GPMC_SLEEP_UV)
    else $error("undervoltage sleep not entered");

  uv_static_a: assert property (active && !line_static |=> active)
    else $error("sleep entered without a static line");

  uv_wake_a: assert property (state == GPMC_SLEEP_UV && line_edge |=> active)
    else $error("undervoltage sleep did not wake on a line change");

  presence_arm_a: assert property (active && next_state != GPMC_ACTIVE && !line_lvl
      |=> presence_suppress [*1] ##0 !active)
    else $error("presence suppression not armed");

  offset_hold_a: assert property (cur_end && offset_conv |=>
      $stable(results.current) && offset_corr == $past(sense_input))
    else $error("offset slot disturbed current result");

  acc_add_a: assert property (cur_end && !offset_conv && cur_acc_in >= 0 |=>
      charge_accumulator >= $past(charge_accumulator))
    else $error("accumulator did not take the conversion");

  offset_slot_a: assert property (cur_end && conv_cnt == OFFSET_SLOT |=>
      conv_cnt == '0 && !adc_offset_mode)
    else $error("offset slot spacing wrong");

endmodule

// [rtl/gpmc_pkg.sv]
/*
  Constants, types and carriers for the gauge power and measurement controller.
  Assumes a single 40 MHz system clock and converter front ends on that clock.
*/
// Contract
// - power-up enters ACTIVE with measurements running
// - SLEEP stops measuring, keeps every register
// - bus-low enable plus line low 2s: sleep
// - bus-low sleep wakes when line goes high
// - undervoltage enable plus voltage below threshold: sleep
// - undervoltage sleep also needs static line 2s
// - undervoltage sleep wakes on any line change
// - line low in sleep: no presence on rise
// - line high at undervoltage entry: reset accepted
// - voltage every 440ms, 9.76mV LSB, saturating
// - temperature every 440ms, 0.125C LSB
// - current every 3.515s, clamped 7FFFh/8000h
// - sample at 18.6kHz, update per conversion
// - every 1024th conversion measures offset
// - offset cycle repeats prior current result
// - offset trim added to every raw sample
// - offset trim volatile, master rewrites after power-up
// - 11-bit gain, 0 to 1.999, 2^-10 steps
// - read-only factory gain copy at B0h/B1h
// - 8-bit tempco, 30.5ppm steps, zero disables
// - tempco recomputed on each 0.5C crossing
// - each conversion adds current into accumulator
package gpmc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int SLEEP_DETECT_MS = 2000;
  localparam int SLEEP_CYC = SLEEP_DETECT_MS * (CLK_HZ / 1000);
  localparam int VOLT_PERIOD_MS = 440;
  localparam int VOLT_CYC = VOLT_PERIOD_MS * (CLK_HZ / 1000);
  localparam int CUR_PERIOD_US = 3_515_000;
  localparam int CUR_CYC = CUR_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int SAMPLE_RATE_HZ = 18_600;
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int CONV_CNT_W = 10;

  // ****************************************
  // widths and formats
  // ****************************************
  localparam int RAW_W = 16;
  localparam int VOLT_W = 11;
  localparam int TEMP_W = 11;
  localparam int CUR_W = 16;
  localparam int GAIN_W = 11;
  localparam int GAIN_FRAC = 10;
  localparam int TC_W = 8;
  localparam int TC_SHIFT = 16;
  localparam int ACC_W = 32;
  localparam logic signed [9:0] TC_REF_HALF = 10'sh032;
  localparam logic [VOLT_W-1:0] SLEEP_VOLTAGE_THRESHOLD_LO = 11'h0FB;
  localparam logic [VOLT_W-1:0] SLEEP_VOLTAGE_THRESHOLD_HI = 11'h1F6;
  localparam logic signed [CUR_W-1:0] CUR_MAX = 16'sh7FFF;
  localparam logic signed [CUR_W-1:0] CUR_MIN = 16'sh8000;
  localparam logic [15:0] FACTORY_GAIN_DEF = 16'h0400;

  // ****************************************
  // byte address map
  // ****************************************
  localparam logic [7:0] ADDR_TEMP_MSB = 8'h0A;
  localparam logic [7:0] ADDR_TEMP_LSB = 8'h0B;
  localparam logic [7:0] ADDR_VOLT_MSB = 8'h0C;
  localparam logic [7:0] ADDR_VOLT_LSB = 8'h0D;
  localparam logic [7:0] ADDR_CUR_MSB = 8'h0E;
  localparam logic [7:0] ADDR_CUR_LSB = 8'h0F;
  localparam logic [7:0] ADDR_COB = 8'h7B;
  localparam logic [7:0] ADDR_GAIN_MSB = 8'h78;
  localparam logic [7:0] ADDR_GAIN_LSB = 8'h79;
  localparam logic [7:0] ADDR_TC = 8'h7A;
  localparam logic [7:0] ADDR_FGAIN_MSB = 8'hB0;
  localparam logic [7:0] ADDR_FGAIN_LSB = 8'hB1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {GPMC_ACTIVE, GPMC_SLEEP_BUS, GPMC_SLEEP_UV} gpmc_pwr_t;

  typedef struct packed {
    logic bus_low_en;
    logic uv_en;
    logic vsel_high;
  } gpmc_sleep_cfg_t;

  typedef struct packed {
    logic signed [CUR_W-1:0] current;
    logic signed [TEMP_W-1:0] temp;
    logic signed [VOLT_W-1:0] volt;
  } gpmc_results_t;

endpackage

// [rtl/gpmc_line_watch.sv]
/*
  Data line watcher: synchroniser, edge detect and static-level timer.
  Assumes the line pin is asynchronous to sys_clk.
*/
`timescale 1ns/10ps
module gpmc_line_watch import gpmc_pkg::*; #(
  parameter int STATIC_CYC = SLEEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic line_pin,
  output logic line_lvl,
  output logic line_rise,
  output logic line_edge,
  output logic line_static
);

  localparam int CNT_W = $clog2(STATIC_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STATIC_CYC - 1);

  logic sync_1;
  logic sync_2;
  logic line_prev;
  logic [CNT_W-1:0] static_cnt;

  // two stages before anything reads the pin; third stage only for edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
      line_prev <= 1'b0;
    end else begin
      sync_1 <= line_pin;
      sync_2 <= sync_1;
      line_prev <= sync_2;
    end
  end

  assign line_lvl = sync_2;
  assign line_rise = sync_2 & ~line_prev;
  assign line_edge = sync_2 ^ line_prev;
  assign line_static = (static_cnt == CNT_LAST);

  // a glitch of one cycle is enough to restart the interval
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      static_cnt <= '0;
    end else if (line_edge) begin
      static_cnt <= '0;
    end else if (!line_static) begin
      static_cnt <= static_cnt + CNT_W'(1);
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  timer_restart_a: assert property (line_edge |=> static_cnt == '0)
    else $error("static timer not restarted by a line transition");

endmodule

// [sim/gpmc_master_model.sv]
/*
  Behavioural single-wire bus master that drives the gauge data line.
  Assumes an external pull-up, so a released line reads high, never unknown.
*/
`timescale 1ns/10ps
module gpmc_master_model #(
  parameter int RST_LOW_CYC = 20
) (
  input wire logic sys_clk,
  output logic dq
);
  // ****************************************
  // line control
  // ****************************************
  // the pull-up holds the line high until the master acts
  initial begin
    dq = 1'b1;
  end

  // pack removed or host shut down: the line sits low
  task automatic hold_low();
    @(posedge sys_clk);
    dq <= 1'b0;
  endtask

  task automatic release_line();
    @(posedge sys_clk);
    dq <= 1'b1;
  endtask

  // release first, then a reset pulse; talking also wakes an undervoltage sleep
  task automatic bus_reset(input int gap);
    release_line();
    repeat (gap) @(posedge sys_clk);
    dq <= 1'b0;
    repeat (RST_LOW_CYC) @(posedge sys_clk);
    dq <= 1'b1;
  endtask

  // traffic whose low spans stay short of the sleep detect time
  task automatic traffic(input int n, input int span);
    repeat (n) begin
      hold_low();
      repeat (span) @(posedge sys_clk);
      dq <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule

// [sim/tb_gauge_power_and_measurement_ctrl.sv]
/*
  Self-checking bench for the gauge power and measurement controller.
  Assumes shortened counts below; the master model drives the data line.
*/
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module tb_gauge_power_and_measurement_ctrl
  import gpmc_pkg::*;
;
  localparam int SLP = 64;
  localparam int VPER = 32;
  localparam int CPER = 40;
  logic sys_clk, rst_n, dq, reg_wr, adc_sample, adc_offset_mode;
  logic meas_strobe, cur_strobe, sleep_mode, presence_suppress, slept;
  gpmc_sleep_cfg_t sleep_cfg;
  logic signed [RAW_W-1:0] pack_voltage_input, sense_input;
  logic signed [TEMP_W-1:0] temp_raw;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  gpmc_results_t results, res;
  logic signed [ACC_W-1:0] charge_accumulator, acc0;
  integer seed, error_cnt, n_tests, conv_cnt, samp_gap, samp_last, i, n, c;
  logic signed [7:0] trim_v;
  logic [10:0] gain_v;
  logic [7:0] tc_v;
  longint ofs_v;
  logic signed [15:0] vtab [3] = '{16'sh7FFF, -16'sh07D0, 16'sh012C};
  logic signed [10:0] vexp [3] = '{11'sh3FF, 11'sh400, 11'sh12C};

  gpmc_ctrl #(.SLEEP_CYCLES(SLP), .VOLT_CYCLES(VPER), .CUR_CYCLES(CPER)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .dq_in(dq), .sleep_cfg(sleep_cfg),
    .pack_voltage_input(pack_voltage_input), .temp_raw(temp_raw),
    .sense_input(sense_input), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_sample(adc_sample),
    .adc_offset_mode(adc_offset_mode), .meas_strobe(meas_strobe),
    .cur_strobe(cur_strobe), .results(results),
    .charge_accumulator(charge_accumulator), .sleep_mode(sleep_mode),
    .presence_suppress(presence_suppress));

  gpmc_master_model i_master (.sys_clk(sys_clk), .dq(dq));

  // ****************************************
  // clock, bookkeeping and expectations
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // strobe count, sample spacing and a sticky sleep flag, kept off the test flow
  always @(posedge sys_clk) begin
    if (cur_strobe === 1'b1) conv_cnt <= conv_cnt + 1;
    samp_gap <= (adc_sample === 1'b1) ? 1 : samp_gap + 1;
    if (adc_sample === 1'b1) samp_last <= samp_gap;
    if (sleep_mode === 1'b1) slept <= 1'b1;
  end

  // current as the trims should shape it; wide math so no step wraps early
  function automatic logic signed [15:0] exp_cur(input longint raw, input longint t);
    longint v;
    longint term;
    v = ((raw - ofs_v + longint'(trim_v)) * longint'(gain_v)) >>> 10;
    term = longint'(tc_v) * ((t >>> 2) - 50);
    v = v - ((v * term) >>> 16);
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction

  // ****************************************
  // drivers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data is registered: give it the edge after the address lands
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(reg_rdata, e)
  endtask

  task automatic wait_pulse(input bit cur);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (((cur ? cur_strobe : meas_strobe) !== 1'b1) && k < 300);
    #1;
    `CHK(k < 300, 1'b1)
  endtask

  task automatic wait_sleep(input logic lvl, output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (sleep_mode !== lvl && k < 300);
  endtask

  task automatic cur_chk(input logic signed [15:0] raw);
    logic signed [15:0] e;
    @(posedge sys_clk);
    sense_input <= raw;
    #1;
    acc0 = charge_accumulator;
    e = exp_cur(raw, temp_raw);
    wait_pulse(1'b1);
    `CHK(results.current, e)
    `CHK(charge_accumulator, acc0 + e)
  endtask

  task automatic tdone(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  task automatic test_done();
    $display("TB: %0d compares, %0d mismatches", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a hang costs a mismatch and still ends through the common exit
  initial begin
    repeat (80000) @(posedge sys_clk);
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    test_done();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    sleep_cfg = '0;
    pack_voltage_input = 16'sh012C;
    temp_raw = 11'sh0CB;
    sense_input = '0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    seed = 32'h411ED8ED;
    {error_cnt, n_tests, conv_cnt, samp_gap, samp_last} = '0;
    slept = 1'b0;
    trim_v = '0;
    gain_v = FACTORY_GAIN_DEF[10:0];
    tc_v = '0;
    ofs_v = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    `CHK(sleep_mode, 1'b0)
    wait_pulse(1'b0);
    `CHK(results.temp, temp_raw)
    rd_chk(ADDR_COB, 8'h00);
    rd_chk(ADDR_TC, 8'h00);
    wr(ADDR_FGAIN_MSB, 8'hFF);
    rd_chk(ADDR_FGAIN_MSB, FACTORY_GAIN_DEF[15:8]);
    rd_chk(ADDR_FGAIN_LSB, FACTORY_GAIN_DEF[7:0]);
    rd_chk(8'h55, 8'h00);
    for (i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      pack_voltage_input <= vtab[i];
      wait_pulse(1'b0);
      `CHK(results.volt, vexp[i])
    end
    rd_chk(ADDR_VOLT_MSB, 8'h01);
    tdone("power-up");
    for (i = 0; i < 8; i++) begin
      trim_v = $random(seed) % 16;
      wr(ADDR_COB, trim_v);
      cur_chk($random(seed) % 20000);
    end
    trim_v = 8'sh05;
    wr(ADDR_COB, trim_v);
    cur_chk(16'sh7FFF);
    trim_v = -8'sh05;
    wr(ADDR_COB, trim_v);
    cur_chk(16'sh8000);
    trim_v = '0;
    wr(ADDR_COB, 8'h00);
    gain_v = 11'h200;
    wr(ADDR_GAIN_MSB, 8'h02);
    wr(ADDR_GAIN_LSB, 8'h00);
    cur_chk(16'sh0BB9);
    gain_v = 11'h7FF;
    wr(ADDR_GAIN_MSB, 8'h07);
    wr(ADDR_GAIN_LSB, 8'hFF);
    cur_chk(16'sh03E8);
    gain_v = FACTORY_GAIN_DEF[10:0];
    wr(ADDR_GAIN_MSB, FACTORY_GAIN_DEF[15:8]);
    wr(ADDR_GAIN_LSB, FACTORY_GAIN_DEF[7:0]);
    cur_chk(16'sh0BB9);
    tc_v = 8'h40;
    wr(ADDR_TC, tc_v);
    cur_chk(16'sh0400);
    @(posedge sys_clk);
    temp_raw <= 11'sh0CC;
    wait_pulse(1'b0);
    cur_chk(16'sh0400);
    tc_v = 8'h00;
    wr(ADDR_TC, tc_v);
    cur_chk(16'sh0400);
    tdone("current");
    i_master.hold_low();
    repeat (SLP + 20) @(posedge sys_clk);
    `CHK(sleep_mode, 1'b0)
    i_master.release_line();
    // the synced view still shows the old static low for a few cycles
    repeat (4) @(posedge sys_clk);
    sleep_cfg.bus_low_en <= 1'b1;
    slept = 1'b0;
    i_master.traffic(4, SLP - 24);
    `CHK(slept, 1'b0)
    i_master.hold_low();
    wait_sleep(1'b1, n);
    `CHK(n >= SLP - 4 && n <= SLP + 8, 1'b1)
    `CHK(presence_suppress, 1'b1)
    res = results;
    acc0 = charge_accumulator;
    c = conv_cnt;
    @(posedge sys_clk);
    sense_input <= 16'sh0309;
    pack_voltage_input <= 16'sh0190;
    repeat (3 * CPER) @(posedge sys_clk);
    #1;
    `CHK(results, res)
    `CHK(charge_accumulator, acc0)
    `CHK(conv_cnt, c)
    i_master.release_line();
    wait_sleep(1'b0, n);
    `CHK(n <= 5, 1'b1)
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(presence_suppress, 1'b0)
    i_master.bus_reset(10);
    tdone("bus-low sleep");
    @(posedge sys_clk);
    sleep_cfg <= '{bus_low_en: 1'b0, uv_en: 1'b1, vsel_high: 1'b0};
    wait_pulse(1'b0);
    repeat (SLP + 20) @(posedge sys_clk);
    `CHK(sleep_mode, 1'b0)
    // break the static line before the threshold rises above the voltage
    i_master.hold_low();
    i_master.release_line();
    repeat (3) @(posedge sys_clk);
    @(posedge sys_clk);
    sleep_cfg.vsel_high <= 1'b1;
    slept = 1'b0;
    i_master.traffic(3, SLP - 34);
    `CHK(slept, 1'b0)
    wait_sleep(1'b1, n);
    `CHK(n >= SLP - 4 && n <= SLP + 8, 1'b1)
    `CHK(presence_suppress, 1'b0)
    i_master.hold_low();
    wait_sleep(1'b0, n);
    `CHK(n <= 5, 1'b1)
    @(posedge sys_clk);
    sleep_cfg <= '0;
    i_master.bus_reset(10);
    tdone("undervoltage sleep");
    while (conv_cnt < 1022) wait_pulse(1'b1);
    cur_chk(16'sh0384);
    `CHK(adc_offset_mode, 1'b1)
    @(posedge sys_clk);
    sense_input <= 16'sh0014;
    #1;
    acc0 = charge_accumulator;
    res = results;
    wait_pulse(1'b1);
    `CHK(results.current, res.current)
    `CHK(charge_accumulator, acc0 + res.current)
    `CHK(adc_offset_mode, 1'b0)
    ofs_v = 20;
    cur_chk(16'sh0384);
    `CHK(samp_last, SAMPLE_CYC)
    tdone("offset slot");
    test_done();
  end
endmodule
